// >>> core/ddrbl_burst.sv
// Burst read/write sequencer of the SDRAM core with a two-entry beat buffer
// Summary of operation
// - OTF with A12 low gives chop four, spacing 4.
// - OTF A12 high gives eight; never column bit.
// - OTF choice on reads, writes, with/without autoprecharge.
// - Eight beats for field 00, or 01 with A12.
// - Field 10 gives fixed chopped four-beat bursts.
// - Setup/hold violation corrupts that beat and all later beats of the burst.
// - Strobe violations corrupt only that write; no hang.
// - One mask per eight data lines, data timing.
// - Mask ignored on reads; TDQS mode disables masking.
`timescale 1ns/10ps
module ddrbl_burst (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  // Mode settings
  input  wire logic [1:0]            bl_mode_i,
  input  wire logic                  tdqs_en_i,
  // Column command
  input  wire logic                  cmd_valid_i,
  input  wire ddrbl_pkg::ddrbl_cmd_t cmd_i,
  output logic                       cmd_ready_o,
  // Write data beats
  input  wire logic                  wr_valid_i,
  input  wire ddrbl_pkg::ddrbl_wdata_t wr_i,
  input  wire logic                  wr_viol_i,
  output logic                       wr_ready_o,
  // Beats toward the array
  output logic                       beat_valid_o,
  input  wire logic                  beat_ready_i,
  output ddrbl_pkg::ddrbl_beat_t     beat_o,
  // Status
  output logic                       burst_len8_o,
  output logic                       ap_pre_o
);
  ddrbl_pkg::ddrbl_state_s_t s_q;
  ddrbl_pkg::ddrbl_state_s_t s_d;

  logic                   cmd_acc;
  logic                   sel_len8;
  logic                   push;
  logic                   pop;
  logic                   last;
  logic [2:0]             idx;
  logic [1:0]             widx;
  ddrbl_pkg::ddrbl_beat_t pbeat;

  // Burst length choice; A12 only steers length
  assign sel_len8 = (bl_mode_i == ddrbl_pkg::BL_FIXED8) ||
                    ((bl_mode_i == ddrbl_pkg::BL_OTF) && cmd_i.a12);

  assign cmd_ready_o  = (s_q.st == ddrbl_pkg::DDRBL_IDLE) && (s_q.ccd >= ddrbl_pkg::CCD_CYC);
  assign cmd_acc      = cmd_valid_i && cmd_ready_o;
  assign wr_ready_o   = (s_q.st == ddrbl_pkg::DDRBL_WRITE) && (s_q.fcnt != ddrbl_pkg::FIFO_DEPTH);
  assign beat_valid_o = (s_q.fcnt != 2'h0);
  assign beat_o       = s_q.fifo[0];
  assign pop          = beat_valid_o && beat_ready_i;
  // Free slot; two entries need only bit zero
  assign widx         = s_q.fcnt - {1'b0, pop};
  assign burst_len8_o = s_q.len8;
  assign ap_pre_o     = s_q.pre;
  assign last         = (s_q.cnt == (s_q.len8 ? ddrbl_pkg::LAST_BL8 : ddrbl_pkg::LAST_BC4));

  // Beat order wraps inside the nibble or the eight-beat block
  assign idx = s_q.len8 ? s_q.cmd.col[2:0] + s_q.cnt[2:0]
                        : {s_q.cmd.col[2], s_q.cmd.col[1:0] + s_q.cnt[1:0]};

  always_comb begin
    push          = 1'b0;
    pbeat         = '0;
    pbeat.wr      = (s_q.st == ddrbl_pkg::DDRBL_WRITE);
    pbeat.bank    = s_q.cmd.bank;
    pbeat.col     = {s_q.cmd.col[ddrbl_pkg::COL_W-1:3], idx};
    if (s_q.st == ddrbl_pkg::DDRBL_WRITE) begin
      push          = wr_valid_i && wr_ready_o;
      pbeat.data    = wr_i.dq;
      pbeat.mask    = tdqs_en_i ? '0 : wr_i.dm;
      pbeat.corrupt = s_q.viol || wr_viol_i;
    end else if (s_q.st == ddrbl_pkg::DDRBL_READ) begin
      push = (s_q.fcnt != ddrbl_pkg::FIFO_DEPTH);
    end
  end

  always_comb begin
    s_d     = s_q;
    s_d.pre = 1'b0;
    if (s_q.ccd < ddrbl_pkg::CCD_CYC) begin
      s_d.ccd = s_q.ccd + 3'h1;
    end
    unique case (s_q.st)
      ddrbl_pkg::DDRBL_IDLE: begin
        if (cmd_acc) begin
          s_d.cmd  = cmd_i;
          s_d.len8 = sel_len8;
          s_d.cnt  = ddrbl_pkg::CNT_RST;
          s_d.viol = 1'b0;
          s_d.ccd  = 3'h1;
          s_d.st   = cmd_i.wr ? ddrbl_pkg::DDRBL_WRITE : ddrbl_pkg::DDRBL_READ;
        end
      end
      ddrbl_pkg::DDRBL_WRITE: begin
        if (wr_viol_i) begin
          s_d.viol = 1'b1;
        end
        if (push) begin
          s_d.cnt = s_q.cnt + 4'h1;
          if (last) begin
            s_d.st  = ddrbl_pkg::DDRBL_IDLE;
            s_d.pre = s_q.cmd.ap;
          end
        end
      end
      ddrbl_pkg::DDRBL_READ: begin
        if (push) begin
          s_d.cnt = s_q.cnt + 4'h1;
          if (last) begin
            s_d.st  = ddrbl_pkg::DDRBL_IDLE;
            s_d.pre = s_q.cmd.ap;
          end
        end
      end
    endcase
    // Two-entry buffer, head at slot 0
    if (pop) begin
      s_d.fifo[0] = s_q.fifo[1];
    end
    if (push) begin
      s_d.fifo[widx[0]] = pbeat;
    end
    s_d.fcnt = s_q.fcnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_q     <= '0;
      s_q.st  <= ddrbl_pkg::DDRBL_IDLE;
      s_q.ccd <= ddrbl_pkg::CCD_CYC;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_wr_last;
    (s_q.st == ddrbl_pkg::DDRBL_WRITE) && push && last;
  endsequence

  // Burst start and the shortest run of busy cycles for each length
  sequence s_bc4_take;
    cmd_acc && !sel_len8;
  endsequence

  sequence s_bl8_take;
    cmd_acc && sel_len8;
  endsequence

  sequence s_bc4_busy;
    (s_q.st != ddrbl_pkg::DDRBL_IDLE && !burst_len8_o) [*4];
  endsequence

  sequence s_bl8_busy;
    (s_q.st != ddrbl_pkg::DDRBL_IDLE && burst_len8_o) [*8];
  endsequence

  a_ccd_spacing: assert property (cmd_acc |=> !cmd_ready_o [*3])
    else $error("column command accepted before spacing elapsed");
  a_fixed4_len: assert property (cmd_acc && bl_mode_i == ddrbl_pkg::BL_FIXED4 |=> !burst_len8_o)
    else $error("fixed chop mode gave eight beats");
  a_otf_len: assert property (cmd_acc && bl_mode_i == ddrbl_pkg::BL_OTF |=> burst_len8_o == $past(cmd_i.a12))
    else $error("on-the-fly length does not follow A12");
  a_fixed8_len: assert property (cmd_acc && bl_mode_i == ddrbl_pkg::BL_FIXED8 |=> burst_len8_o)
    else $error("fixed eight mode gave a chop");
  a_col_kept: assert property (cmd_acc |=> s_q.cmd.col == $past(cmd_i.col))
    else $error("column changed by length select");
  a_read_mask: assert property (beat_valid_o && !beat_o.wr |-> beat_o.mask == '0)
    else $error("mask applied to a read beat");
  a_mask_pass: assert property (push && pbeat.wr && s_q.fcnt == 2'h0 |=>
    beat_valid_o && beat_o.mask == ($past(tdqs_en_i) ? 2'h0 : $past(wr_i.dm)))
    else $error("write mask not taken with its data");
  a_viol_clear: assert property (cmd_acc |=> !s_q.viol)
    else $error("violation leaked into next burst");
  a_no_hang: assert property (s_wr_last |=> s_q.st == ddrbl_pkg::DDRBL_IDLE && cmd_ready_o)
    else $error("sequencer did not return to idle");
  a_ap_pulse: assert property (s_wr_last and (s_q.cmd.ap == 1'b1) |=> ap_pre_o ##1 !ap_pre_o)
    else $error("auto precharge not signalled");
  a_ap_quiet: assert property (s_wr_last and (s_q.cmd.ap == 1'b0) |=> !ap_pre_o)
    else $error("auto precharge signalled without request");

  // Burst length, command refusal and column order within a burst
  a_bc4_busy: assert property (s_bc4_take |=> s_bc4_busy)
    else $error("chopped burst ended early");
  a_bl8_busy: assert property (s_bl8_take |=> s_bl8_busy)
    else $error("eight-beat burst ended early");
  a_busy_refuse: assert property (s_q.st != ddrbl_pkg::DDRBL_IDLE |-> !cmd_ready_o)
    else $error("command offered while a burst runs");
  a_len_steady: assert property (s_q.st != ddrbl_pkg::DDRBL_IDLE |=> $stable(burst_len8_o))
    else $error("burst length changed inside a burst");
  a_bc4_nibble: assert property (push && !s_q.len8 |-> pbeat.col[2] == s_q.cmd.col[2])
    else $error("chopped burst left its nibble");
  a_upper_col: assert property (push |->
    pbeat.col[ddrbl_pkg::COL_W-1:3] == s_q.cmd.col[ddrbl_pkg::COL_W-1:3])
    else $error("upper column bits changed within a burst");

  // Beat buffer and write path
  a_wr_gate: assert property (s_q.st != ddrbl_pkg::DDRBL_WRITE |-> !wr_ready_o)
    else $error("write beat offered outside a write burst");
  a_buf_hold: assert property (beat_valid_o && !beat_ready_i |=> beat_valid_o && $stable(beat_o))
    else $error("stalled beat lost or changed");
  a_fifo_bound: assert property (s_q.fcnt <= ddrbl_pkg::FIFO_DEPTH)
    else $error("beat buffer overfilled");
  a_rd_clean: assert property (push && !pbeat.wr |-> pbeat.data == '0 && !pbeat.corrupt)
    else $error("read beat marked corrupt or carries data");
  a_viol_sticky: assert property (s_q.st == ddrbl_pkg::DDRBL_WRITE && wr_viol_i |=> s_q.viol)
    else $error("violation not kept for the rest of the burst");
endmodule : ddrbl_burst

// >>> core/ddrbl_pkg.sv
// Constants and types shared by the burst read and write sequencer
package ddrbl_pkg;
  localparam int unsigned DQ_W   = 16;
  localparam int unsigned DM_W   = DQ_W / 8;
  localparam int unsigned COL_W  = 10;
  localparam int unsigned BANK_W = 3;

  // Burst length field of mode register zero
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Last beat index per burst kind, and column-to-column spacing
  localparam logic [3:0] LAST_BL8   = 4'h7;
  localparam logic [3:0] LAST_BC4   = 4'h3;
  localparam logic [2:0] CCD_CYC    = 3'h4;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [1:0] {DDRBL_IDLE, DDRBL_WRITE, DDRBL_READ} ddrbl_state_t;

  typedef struct packed {
    logic              wr;
    logic              ap;
    logic              a12;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
  } ddrbl_cmd_t;

  typedef struct packed {
    logic [DQ_W-1:0] dq;
    logic [DM_W-1:0] dm;
  } ddrbl_wdata_t;

  typedef struct packed {
    logic              wr;
    logic              corrupt;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
    logic [DQ_W-1:0]   data;
    logic [DM_W-1:0]   mask;
  } ddrbl_beat_t;

  typedef struct packed {
    ddrbl_state_t     st;
    logic [3:0]       cnt;
    logic             len8;
    logic             viol;
    logic [2:0]       ccd;
    logic             pre;
    ddrbl_cmd_t       cmd;
    logic [1:0]       fcnt;
    ddrbl_beat_t [1:0] fifo;
  } ddrbl_state_s_t;

  localparam logic [3:0] CNT_RST = 4'h0;
endpackage : ddrbl_pkg

// >>> test/ddrbl_ctrl_model.sv
// Controller model: holds commands until taken, streams write beats
`timescale 1ns/10ps
module ddrbl_ctrl_model #(
  parameter int unsigned AL_CYC    = 0,
  parameter int unsigned T_RTP_CYC = 4,
  parameter int unsigned T_RAS_CYC = 8,
  parameter int unsigned T_RP_CYC  = 4,
  parameter int unsigned T_RC_CYC  = 12,
  parameter int unsigned T_WR_CYC  = 4,
  parameter int unsigned T_WTR_CYC = 4
) (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  // Bench requests
  input  wire logic                    req_i,
  input  wire ddrbl_pkg::ddrbl_cmd_t   req_cmd_i,
  input  wire logic                    viol_i,
  // Device side
  output logic                         cmd_valid_o,
  output ddrbl_pkg::ddrbl_cmd_t        cmd_o,
  input  wire logic                    cmd_ready_i,
  output logic                         wr_valid_o,
  output ddrbl_pkg::ddrbl_wdata_t      wr_o,
  input  wire logic                    wr_ready_i,
  output logic                         wr_viol_o
);
  // Earliest precharge after a read, then reopen after the precharge
  localparam int unsigned RD_PRE  = AL_CYC + T_RTP_CYC;
  localparam int unsigned PRE_AT  = (RD_PRE > T_RAS_CYC) ? RD_PRE : T_RAS_CYC;
  localparam int unsigned RD_OPEN = (PRE_AT + T_RP_CYC > T_RC_CYC) ? PRE_AT + T_RP_CYC : T_RC_CYC;
  localparam int unsigned WR_OPEN = (T_WR_CYC + T_RP_CYC > T_RC_CYC) ? T_WR_CYC + T_RP_CYC : T_RC_CYC;

  logic [7:0] hold_q [8];
  logic [7:0] wtr_q;
  logic       pend_q;
  logic       wr_ap_q;
  logic [2:0] wr_bank_q;
  logic       go;
  logic       taken;
  logic       beat_taken;
  logic       rd_close;
  logic       wr_close;

  assign wr_valid_o = 1'b1;
  assign wr_viol_o  = viol_i;
  assign taken      = cmd_valid_o && cmd_ready_i;
  assign beat_taken = wr_valid_o && wr_ready_i;
  assign rd_close   = taken && !cmd_o.wr && cmd_o.ap;
  assign wr_close   = beat_taken && wr_ap_q;
  // A command goes out only once every timer of its bank has run out
  assign go = pend_q && (hold_q[cmd_o.bank] == 8'h00) && (cmd_o.wr || (wtr_q == 8'h00));

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o       <= '0;
      wr_o        <= '0;
      pend_q      <= 1'b0;
      wtr_q       <= 8'h00;
      wr_ap_q     <= 1'b0;
      wr_bank_q   <= 3'h0;
      for (int b = 0; b < 8; b++) begin
        hold_q[b] <= 8'h00;
      end
    end else begin
      if (req_i) begin
        pend_q <= 1'b1;
        cmd_o  <= req_cmd_i;
      end else if (go) begin
        pend_q      <= 1'b0;
        cmd_valid_o <= 1'b1;
      end else if (taken) begin
        cmd_valid_o <= 1'b0;
      end
      if (taken && cmd_o.wr) begin
        wr_ap_q   <= cmd_o.ap;
        wr_bank_q <= cmd_o.bank;
      end
      for (int b = 0; b < 8; b++) begin
        if (rd_close && (cmd_o.bank == 3'(b))) begin
          hold_q[b] <= 8'(RD_OPEN);
        end else if (wr_close && (wr_bank_q == 3'(b))) begin
          hold_q[b] <= 8'(WR_OPEN);
        end else if (hold_q[b] != 8'h00) begin
          hold_q[b] <= hold_q[b] - 8'h01;
        end
      end
      if (beat_taken) begin
        wtr_q   <= 8'(T_WTR_CYC);
        wr_o.dq <= wr_o.dq + 16'h0001;
        wr_o.dm <= wr_o.dm + 2'h1;
      end else if (wtr_q != 8'h00) begin
        wtr_q <= wtr_q - 8'h01;
      end
    end
  end
endmodule : ddrbl_ctrl_model

// >>> test/ddrbl_burst_bench.sv
// Self-checking bench of the burst sequencer
`timescale 1ns/10ps
module ddrbl_burst_bench;
  typedef struct packed {logic [1:0] m; logic a, w, p, t, v, s; logic [3:0] n;} ddrbl_row_t;
  logic                    ref_clk_i = 0, reset_i = 1, req = 0, viol = 0, stall = 0, tdqs = 0;
  logic                    cv, cr, wv, wrr, wvi, bv, len8, ap, beat_ready;
  logic [1:0]              mode = 0;
  logic [15:0]             edq = 0;
  int                      n_fail = 0, comparisons = 0, cyc = 0, n_ap = 0;
  ddrbl_pkg::ddrbl_cmd_t   rcmd = '0, cmd;
  ddrbl_pkg::ddrbl_wdata_t wr;
  ddrbl_pkg::ddrbl_beat_t  beat;
  ddrbl_row_t              rows [6] = '{'{0,0,1,0,0,0,0,8}, '{1,1,0,1,0,0,1,8}, '{1,0,1,1,1,0,0,4},
                                        '{1,0,0,0,0,0,0,4}, '{2,1,1,0,0,0,1,4}, '{3,1,0,0,0,0,0,4}};
  assign beat_ready = !stall || cyc[1];
  always #10 ref_clk_i = ~ref_clk_i;
  ddrbl_burst ddrbl_burst_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bl_mode_i(mode), .tdqs_en_i(tdqs),
    .cmd_valid_i(cv), .cmd_i(cmd), .cmd_ready_o(cr), .wr_valid_i(wv), .wr_i(wr), .wr_viol_i(wvi),
    .wr_ready_o(wrr), .beat_valid_o(bv), .beat_ready_i(beat_ready), .beat_o(beat),
    .burst_len8_o(len8), .ap_pre_o(ap));
  ddrbl_ctrl_model ddrbl_ctrl_model_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req),
    .req_cmd_i(rcmd), .viol_i(viol), .cmd_valid_o(cv), .cmd_o(cmd), .cmd_ready_i(cr),
    .wr_valid_o(wv), .wr_o(wr), .wr_ready_i(wrr), .wr_viol_o(wvi));
  task automatic end_of_test;
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic run(input ddrbl_row_t r);
    int seen;
    int a0;
    seen = 0;
    a0 = n_ap;
    mode = r.m;
    tdqs = r.t;
    viol = r.v;
    stall = r.s;
    rcmd = '{r.w, r.p, r.a, 3'h5, 10'h2F5};
    req = 1;
    @(posedge ref_clk_i);
    #1 req = 0;
    for (int k = 0; k < 200 && seen < r.n; k++) begin
      @(negedge ref_clk_i);
      if (bv && beat_ready) begin
        chk("col", beat.col, r.n == 8 ? {7'h5E, 3'(seen + 5)} : {8'hBD, 2'(seen + 1)});
        chk("data", beat.data, r.w ? edq : 16'h0000);
        chk("mask", beat.mask, r.w && !r.t ? edq[1:0] : 2'h0);
        chk("corrupt", beat.corrupt, r.v);
        chk("kind", beat.wr, r.w);
        edq += r.w;
        seen++;
      end
    end
    repeat (3) @(posedge ref_clk_i);
    #1 chk("beats", seen, r.n);
    chk("len8", len8, r.n == 8);
    chk("extra", bv, 0);
    chk("ap", n_ap - a0, r.p);
  endtask : run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (ap) n_ap <= n_ap + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1 reset_i = 0;
    chk("ready", cr, 1);
    chk("bvalid", bv, 0);
    foreach (rows[i]) run(rows[i]);
    run('{1,1,1,0,0,1,1,8});
    run('{1,0,1,0,0,0,0,4});
    // Reset in the middle of a write burst
    rcmd = '{1'b1, 1'b1, 1'b1, 3'h2, 10'h000};
    req = 1;
    @(posedge ref_clk_i);
    #1 req = 0;
    repeat (3) @(posedge ref_clk_i);
    #1 reset_i = 1;
    repeat (2) @(posedge ref_clk_i);
    #1 reset_i = 0;
    edq = 0;
    chk("rst_ready", cr, 1);
    chk("rst_wready", wrr, 0);
    chk("rst_bvalid", bv, 0);
    chk("rst_len8", len8, 0);
    chk("rst_ap", ap, 0);
    run('{0,0,1,0,0,0,0,8});
    end_of_test;
  end
endmodule : ddrbl_burst_bench
